// ===== odcb_map.svh
`ifndef ODCB_MAP_SVH
`define ODCB_MAP_SVH

// ========================================
// register offsets on the host register port
`define ODCB_ADDR_DELAY 8'h2c
`define ODCB_ADDR_SUPPLY_DRV 8'h2d
`define ODCB_ADDR_TERM_MODE 8'h2f
`define ODCB_ADDR_DIV_UPPER 8'h38
`define ODCB_ADDR_DIV_MIDDLE 8'h39
`define ODCB_ADDR_DIV_LOW 8'h3a
`define ODCB_ADDR_PHASE_STRENGTH 8'h3b

// ========================================
// implemented bits of each register, others read as zero
`define ODCB_MASK_DELAY 8'hff
`define ODCB_MASK_SUPPLY_DRV 8'h1f
`define ODCB_MASK_TERM_MODE 8'hdf
`define ODCB_MASK_DIV_UPPER 8'hff
`define ODCB_MASK_DIV_MIDDLE 8'hff
`define ODCB_MASK_DIV_LOW 8'hff
`define ODCB_MASK_PHASE_STRENGTH 8'hc7

// ========================================
// reset value of every register
`define ODCB_RESET_VALUE 8'h00

// ========================================
// field positions
`define ODCB_COARSE_MSB 5
`define ODCB_COARSE_LSB 0
`define ODCB_FINE_MSB 7
`define ODCB_FINE_LSB 6
`define ODCB_FINE_EXT_BIT 4
`define ODCB_SUPPLY_MSB 4
`define ODCB_SUPPLY_LSB 3
`define ODCB_DRV_MSB 2
`define ODCB_DRV_LSB 0
`define ODCB_MARKER_MSB 7
`define ODCB_MARKER_LSB 6
`define ODCB_MODE_MSB 3
`define ODCB_MODE_LSB 0
`define ODCB_DIV_UPPER_MSB 3
`define ODCB_DIV_UPPER_LSB 0
`define ODCB_PHASE_MSB 7
`define ODCB_PHASE_LSB 6
`define ODCB_STRENGTH_MSB 2
`define ODCB_STRENGTH_LSB 0

// ========================================
// fine delay step and its largest count
`define ODCB_FINE_STEP_PS 8'd30
`define ODCB_FINE_MAX_STEPS 3'd4

`endif

// ===== odcb_pkg.sv
package odcb_pkg;

	// ========================================
	// supply level codes
	typedef enum logic [1:0] {
		ODCB_SUPPLY_1V8 = 2'h0,
		ODCB_SUPPLY_2V5 = 2'h1,
		ODCB_SUPPLY_3V3 = 2'h2
	} odcb_supply_t;

	// ========================================
	// driver standard codes
	typedef enum logic [2:0] {
		ODCB_DRV_LVDS = 3'h0,
		ODCB_DRV_LVPECL_CM = 3'h1,
		ODCB_DRV_CML = 3'h2,
		ODCB_DRV_HCSL = 3'h3,
		ODCB_DRV_LVDS_BOOST = 3'h4,
		ODCB_DRV_LVPECL_NOCM = 3'h5
	} odcb_drv_t;

	// ========================================
	// output termination and single-ended mode codes
	typedef enum logic [3:0] {
		ODCB_MODE_DIFF_EXT = 4'h0,
		ODCB_MODE_DIFF_PULLDN = 4'h1,
		ODCB_MODE_DIFF_PULLUP = 4'h2,
		ODCB_MODE_CMOS_P = 4'h4,
		ODCB_MODE_CMOS_N = 4'h8,
		ODCB_MODE_CMOS_PN = 4'hc
	} odcb_mode_t;

endpackage

// ===== odcb_byte_reg.sv
`timescale 1ns/1ps
`include "odcb_map.svh"

module odcb_byte_reg #(
	parameter logic [7:0] MASK = 8'hff
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] q
);

	// ========================================
	// storage
	logic [7:0] next_q;

	// masked write, unimplemented bits stay zero
	assign next_q = wr_en ? (wr_data & MASK) : q;

	// clears to zero on reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= `ODCB_RESET_VALUE; // see RL11
		end else begin
			q <= next_q; // see RL11
		end
	end

endmodule

// ===== odcb_bank.sv
// Behaviour
// RL1 - low six delay bits: coarse VCO delay
// RL2 - delay bits 7:6: fine 30 ps steps
// RL3 - extended fine code 8:6, 0 to 4
// RL4 - bits 4:3 declare 1.8/2.5/3.3 V supply
// RL5 - bits 2:0 select the driver standard
// RL6 - marker 01/10 means fuse memory written
// RL7 - four-bit code selects termination or CMOS
// RL8 - divider is 20 bits over three registers
// RL9 - phase select routes true/complement to pins
// RL10 - software writes strength field all ones
// RL11 - all fields read back, reset to zero
`timescale 1ns/1ps
`include "odcb_map.svh"

module odcb_bank #(
	parameter int DIV_WIDTH = 20
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic true_clock,
	input wire logic complement_clock,
	output logic [5:0] coarse_delay,
	output logic [2:0] fine_delay_steps,
	output logic [7:0] fine_delay_ps,
	output odcb_pkg::odcb_supply_t supply_level_select,
	output logic supply_level_valid,
	output odcb_pkg::odcb_drv_t driver_standard_select,
	output logic driver_standard_valid,
	output logic fuse_written,
	output odcb_pkg::odcb_mode_t output_mode,
	output logic mode_differential,
	output logic mode_pullup,
	output logic mode_pulldown,
	output logic cmos_pos_en,
	output logic cmos_neg_en,
	output logic mode_valid,
	output logic [DIV_WIDTH-1:0] output_divider,
	output logic positive_pin_source,
	output logic negative_pin_source,
	output logic positive_pin_clock,
	output logic negative_pin_clock,
	output logic [2:0] drive_strength
);

	// ========================================
	// register table
	localparam int NREG = 7;
	localparam int R_DELAY = 0;
	localparam int R_SUPPLY = 1;
	localparam int R_MODE = 2;
	localparam int R_DIVU = 3;
	localparam int R_DIVM = 4;
	localparam int R_DIVL = 5;
	localparam int R_PHASE = 6;

	localparam logic [7:0] REG_ADDR [NREG] = '{
		`ODCB_ADDR_DELAY,
		`ODCB_ADDR_SUPPLY_DRV,
		`ODCB_ADDR_TERM_MODE,
		`ODCB_ADDR_DIV_UPPER,
		`ODCB_ADDR_DIV_MIDDLE,
		`ODCB_ADDR_DIV_LOW,
		`ODCB_ADDR_PHASE_STRENGTH
	};

	localparam logic [7:0] REG_MASK [NREG] = '{
		`ODCB_MASK_DELAY,
		`ODCB_MASK_SUPPLY_DRV,
		`ODCB_MASK_TERM_MODE,
		`ODCB_MASK_DIV_UPPER,
		`ODCB_MASK_DIV_MIDDLE,
		`ODCB_MASK_DIV_LOW,
		`ODCB_MASK_PHASE_STRENGTH
	};

	logic [7:0] q [NREG];
	logic [NREG-1:0] hit;
	logic [7:0] rd_term [NREG];
	logic [7:0] rd_mux;
	logic [7:0] next_rdata;

	// ========================================
	// one byte register per table entry, address decode beside it
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			assign hit[gi] = (reg_addr == REG_ADDR[gi]);
			assign rd_term[gi] = hit[gi] ? q[gi] : 8'h00;
			odcb_byte_reg #(
				.MASK(REG_MASK[gi])
			) u_reg (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.wr_en(reg_wr && hit[gi]), // see RL11
				.wr_data(reg_wdata),
				.q(q[gi])
			);
		end
	endgenerate

	// read mux, unmapped offsets answer zero
	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < NREG; i++) begin
			rd_mux = rd_mux | rd_term[i]; // see RL11
		end
	end

	assign next_rdata = reg_rd ? rd_mux : reg_rdata;

	// read data is held until the next read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= next_rdata;
			reg_rvalid <= reg_rd;
		end
	end

	// ========================================
	// delay decode
	logic [2:0] fine_code;
	logic fine_over;

	assign coarse_delay = q[R_DELAY][`ODCB_COARSE_MSB:`ODCB_COARSE_LSB]; // see RL1
	// extended bit sits in the mode register; zero gives the two-bit form
	assign fine_code = {q[R_MODE][`ODCB_FINE_EXT_BIT],
		q[R_DELAY][`ODCB_FINE_MSB:`ODCB_FINE_LSB]}; // see RL2
	// codes beyond the largest step saturate rather than wrap
	assign fine_over = (fine_code > `ODCB_FINE_MAX_STEPS);
	assign fine_delay_steps = fine_over ? `ODCB_FINE_MAX_STEPS : fine_code; // see RL3
	assign fine_delay_ps = 8'(fine_delay_steps * `ODCB_FINE_STEP_PS); // see RL2

	// ========================================
	// supply and driver decode
	logic [1:0] supply_code;
	logic [2:0] drv_code;

	assign supply_code = q[R_SUPPLY][`ODCB_SUPPLY_MSB:`ODCB_SUPPLY_LSB];
	assign supply_level_select = odcb_pkg::odcb_supply_t'(supply_code); // see RL4
	assign supply_level_valid = (supply_code != 2'h3); // see RL4
	assign drv_code = q[R_SUPPLY][`ODCB_DRV_MSB:`ODCB_DRV_LSB];
	assign driver_standard_select = odcb_pkg::odcb_drv_t'(drv_code); // see RL5
	assign driver_standard_valid = (drv_code <= 3'h5); // see RL5

	// ========================================
	// fuse marker: only the two mixed patterns mean written
	assign fuse_written = q[R_MODE][`ODCB_MARKER_MSB] ^ q[R_MODE][`ODCB_MARKER_LSB]; // see RL6

	// ========================================
	// termination and single-ended mode decode
	logic [3:0] mode_code;

	assign mode_code = q[R_MODE][`ODCB_MODE_MSB:`ODCB_MODE_LSB];
	assign output_mode = odcb_pkg::odcb_mode_t'(mode_code); // see RL7

	// unlisted codes drive nothing and flag invalid
	always_comb begin
		mode_differential = 1'b0;
		mode_pullup = 1'b0;
		mode_pulldown = 1'b0;
		cmos_pos_en = 1'b0;
		cmos_neg_en = 1'b0;
		mode_valid = 1'b1;
		unique case (mode_code)
			4'h0: begin
				mode_differential = 1'b1; // see RL7
			end
			4'h2: begin
				mode_differential = 1'b1;
				mode_pullup = 1'b1; // see RL7
			end
			4'h1: begin
				mode_differential = 1'b1;
				mode_pulldown = 1'b1; // see RL7
			end
			4'h4: begin
				cmos_pos_en = 1'b1; // see RL7
			end
			4'h8: begin
				cmos_neg_en = 1'b1; // see RL7
			end
			4'hc: begin
				cmos_pos_en = 1'b1;
				cmos_neg_en = 1'b1; // see RL7
			end
			default: begin
				mode_valid = 1'b0;
			end
		endcase
	end

	// ========================================
	// divider assembly from three bytes
	assign output_divider = DIV_WIDTH'({q[R_DIVU][`ODCB_DIV_UPPER_MSB:`ODCB_DIV_UPPER_LSB],
		q[R_DIVM], q[R_DIVL]}); // see RL8

	// ========================================
	// cmos phase routing: 0 picks true clock, 1 picks complement
	logic [1:0] phase_code;

	assign phase_code = q[R_PHASE][`ODCB_PHASE_MSB:`ODCB_PHASE_LSB];
	assign positive_pin_source = phase_code[1]; // see RL9
	assign negative_pin_source = (phase_code != 2'h1); // see RL9
	assign positive_pin_clock = positive_pin_source ? complement_clock : true_clock; // see RL9
	assign negative_pin_clock = negative_pin_source ? complement_clock : true_clock; // see RL9

	// strength is passed on as written; software is expected to use all ones
	assign drive_strength = q[R_PHASE][`ODCB_STRENGTH_MSB:`ODCB_STRENGTH_LSB]; // see RL11

endmodule

// ===== odcb_bank_checker.sv
`timescale 1ns/1ps
// ====
// port-level relations of the output configuration bank
module odcb_bank_checker #(
	parameter int DIV_WIDTH = 20
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic true_clock,
	input wire logic complement_clock,
	input wire logic [5:0] coarse_delay,
	input wire logic [2:0] fine_delay_steps,
	input wire logic [7:0] fine_delay_ps,
	input wire logic fuse_written,
	input wire logic [DIV_WIDTH-1:0] output_divider,
	input wire logic positive_pin_source,
	input wire logic positive_pin_clock,
	input wire logic [2:0] drive_strength
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// a write strobe aimed at one offset
	sequence s_wr(a);
		reg_wr && reg_addr == a;
	endsequence
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read valid without a read");
	a_coarse_write: assert property (s_wr(8'h2c) |=> coarse_delay == $past(reg_wdata[5:0]))
		else $error("coarse delay not taken from write");
	a_fine_write: assert property (s_wr(8'h2c) |=>
		fine_delay_steps[1:0] == $past(reg_wdata[7:6]) || fine_delay_steps == 3'd4)
		else $error("fine delay not taken from write");
	a_fine_scale: assert property (fine_delay_steps <= 3'd4 &&
		fine_delay_ps == 8'(fine_delay_steps) * 8'd30)
		else $error("fine delay steps or picoseconds wrong");
	a_fuse_mark: assert property (s_wr(8'h2f) |=> fuse_written == ^$past(reg_wdata[7:6]))
		else $error("fuse marker decode wrong");
	a_div_low: assert property (s_wr(8'h3a) |=> output_divider[7:0] == $past(reg_wdata))
		else $error("divider low byte wrong");
	a_div_upper: assert property (s_wr(8'h38) |=> output_divider[19:16] == $past(reg_wdata[3:0]))
		else $error("divider upper nibble wrong");
	a_pin_route: assert property (s_wr(8'h3b) |=> positive_pin_source == $past(reg_wdata[7]))
		else $error("positive pin source wrong");
	a_pin_clock: assert property (positive_pin_clock ==
		(positive_pin_source ? complement_clock : true_clock))
		else $error("positive pin clock not routed");
	a_strength_hold: assert property ($changed(drive_strength) |-> $past(reg_wr && reg_addr == 8'h3b))
		else $error("strength changed without write");
endmodule

// ===== odcb_host.sv
`timescale 1ns/1ps
// ====
// host processor on the register port
module odcb_host (
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	logic [7:0] rdat;
	logic rok;
	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// one write strobe, then the bus shows no stale value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// one read strobe, answer sampled one edge later
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk_sys);
		rok = reg_rvalid;
		rdat = reg_rdata;
	endtask
endmodule

// ===== odcb_bank_tb.sv
`timescale 1ns/1ps
module odcb_bank_tb;
	logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, v;
	logic true_clock = 1'b0;
	logic complement_clock = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, fine_delay_ps, a, d;
	logic [5:0] coarse_delay;
	logic [2:0] fine_delay_steps, drive_strength;
	logic [19:0] output_divider;
	odcb_pkg::odcb_supply_t supply_level_select;
	odcb_pkg::odcb_drv_t driver_standard_select;
	odcb_pkg::odcb_mode_t output_mode;
	logic supply_level_valid, driver_standard_valid, fuse_written, mode_valid, cmos_pos_en;
	logic cmos_neg_en, positive_pin_source, negative_pin_source, positive_pin_clock;
	logic mode_differential, mode_pullup, mode_pulldown, negative_pin_clock;
	logic [7:0] shadow [256] = '{default: 8'h00};
	logic [7:0] adr [8] = '{8'h2c, 8'h2d, 8'h2f, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h30};
	logic [31:0] seed = 32'd53;
	int num_errors = 0;
	int cmp_count = 0;
	odcb_bank u_odcb_bank (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .true_clock(true_clock), .complement_clock(complement_clock),
		.coarse_delay(coarse_delay), .fine_delay_steps(fine_delay_steps),
		.fine_delay_ps(fine_delay_ps), .supply_level_select(supply_level_select),
		.supply_level_valid(supply_level_valid), .driver_standard_select(driver_standard_select),
		.driver_standard_valid(driver_standard_valid), .fuse_written(fuse_written),
		.output_mode(output_mode), .mode_differential(mode_differential),
		.mode_pullup(mode_pullup), .mode_pulldown(mode_pulldown),
		.cmos_pos_en(cmos_pos_en), .cmos_neg_en(cmos_neg_en), .mode_valid(mode_valid),
		.output_divider(output_divider), .positive_pin_source(positive_pin_source),
		.negative_pin_source(negative_pin_source), .positive_pin_clock(positive_pin_clock),
		.negative_pin_clock(negative_pin_clock), .drive_strength(drive_strength));
	odcb_host u_odcb_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// ====
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] msk(logic [7:0] x);
		case (x)
			8'h2d: return 8'h1f;
			8'h2f: return 8'hdf;
			8'h3b: return 8'hc7;
			8'h2c, 8'h38, 8'h39, 8'h3a: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrs(input logic [7:0] x, input logic [7:0] d);
		u_odcb_host.wr(x, d);
		shadow[x] = d & msk(x);
	endtask
	task automatic rdchk(input logic [7:0] x);
		u_odcb_host.rd(x);
		chk(u_odcb_host.rok, 1);
		chk(u_odcb_host.rdat, shadow[x]);
	endtask
	task automatic chkout();
		logic [2:0] f;
		logic ns;
		@(negedge clk_sys);
		ns = shadow[8'h3b][7:6] != 2'b01;
		f = shadow[8'h2f][4] ? 3'd4 : {1'b0, shadow[8'h2c][7:6]};
		chk(coarse_delay, shadow[8'h2c][5:0]);
		chk(fine_delay_steps, f);
		chk(fine_delay_ps, 8'(f) * 8'd30);
		chk(supply_level_select, shadow[8'h2d][4:3]);
		chk(supply_level_valid, shadow[8'h2d][4:3] != 2'b11);
		chk(driver_standard_select, shadow[8'h2d][2:0]);
		chk(driver_standard_valid, shadow[8'h2d][2:0] <= 3'd5);
		chk(fuse_written, ^shadow[8'h2f][7:6]);
		chk(output_mode, shadow[8'h2f][3:0]);
		chk(output_divider, {shadow[8'h38][3:0], shadow[8'h39], shadow[8'h3a]});
		chk(positive_pin_source, shadow[8'h3b][7]);
		chk(negative_pin_source, shadow[8'h3b][7:6] != 2'b01);
		chk(positive_pin_clock, shadow[8'h3b][7] ? complement_clock : true_clock);
		chk(negative_pin_clock, ns ? complement_clock : true_clock);
		chk(drive_strength, shadow[8'h3b][2:0]);
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ====
	// clock, pin clocks and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		true_clock <= ~true_clock;
		complement_clock <= true_clock;
	end
	initial begin
		#200us;
		num_errors++;
		close_out();
	end
	// ====
	// main sequence
	initial begin
		rst_n = 1'b0;
		repeat (2) begin
			repeat (16) @(posedge clk_sys);
			rst_n <= 1'b1;
			shadow = '{default: 8'h00};
			for (int i = 0; i < 8; i++) rdchk(adr[i]);
			chkout();
			wrs(8'h3b, 8'h07);
			for (int i = 0; i < 16; i++) begin
				wrs(8'h2c, {i[1:0], 6'h3f});
				wrs(8'h2f, {i[1:0], 1'b0, i[2], i[3:0]});
				chkout();
				v = i inside {0, 1, 2, 4, 8, 12};
				chk(mode_valid, v);
				chk(cmos_pos_en, v & i[2]);
				chk(cmos_neg_en, v & i[3]);
				chk(mode_differential, i < 3);
				chk(mode_pullup, i == 2);
				chk(mode_pulldown, i == 1);
			end
			for (int i = 0; i < 8; i++) begin
				wrs(8'h2d, {3'b000, i[1:0], i[2:0]});
				wrs(8'h3b, {i[1:0], 6'h07});
				chkout();
			end
			repeat (60) begin
				a = adr[rnd() % 8];
				d = 8'(rnd());
				if (a == 8'h3b) d[2:0] = 3'b111;
				wrs(a, d);
				chkout();
				rdchk(a);
			end
			@(posedge clk_sys);
			rst_n <= 1'b0;
		end
		close_out();
	end
endmodule
bind odcb_bank odcb_bank_checker #(.DIV_WIDTH(DIV_WIDTH)) u_odcb_bank_checker (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .true_clock(true_clock),
	.complement_clock(complement_clock), .coarse_delay(coarse_delay),
	.fine_delay_steps(fine_delay_steps), .fine_delay_ps(fine_delay_ps),
	.fuse_written(fuse_written), .output_divider(output_divider),
	.positive_pin_source(positive_pin_source), .positive_pin_clock(positive_pin_clock),
	.drive_strength(drive_strength));
